// [afe_pkg.sv]
// Package for the converter front-end control-word decoder.
// Holds addresses, field positions, reset values, mode codes and carrier types.
// Assumes every design file imports it whole.
`default_nettype none
package afe_pkg;

  // ==========================================================================
  // Word layout
  // ==========================================================================
  localparam int unsigned AFE_WORD_W = 16;
  localparam int unsigned AFE_DATA_W = 12;
  localparam int unsigned AFE_ADDR_W = 4;
  localparam logic [4:0] AFE_BITS_PER_WORD = 5'h10;

  // Serial word as shifted in: data bit 11 first, address bit 0 last.
  typedef struct packed {
    logic [11:0] data;
    logic [3:0] addr;
  } afe_word_t;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [3:0] AFE_ADDR_WIDE_POWER_CONTROL = 4'h0;
  localparam logic [3:0] AFE_ADDR_ANCILLARY_LEVEL_ONE = 4'h1;
  localparam logic [3:0] AFE_ADDR_ANCILLARY_LEVEL_TWO = 4'h2;
  localparam logic [3:0] AFE_ADDR_ANCILLARY_LEVEL_THREE = 4'h3;
  localparam logic [3:0] AFE_ADDR_INPHASE_TRIM = 4'h4;
  localparam logic [3:0] AFE_ADDR_QUADRATURE_TRIM = 4'h5;
  localparam logic [3:0] AFE_ADDR_OUTPUT_BIAS_SELECT = 4'h6;
  localparam logic [3:0] AFE_ADDR_HOUSEKEEPING_CONVERSION = 4'h7;
  localparam logic [3:0] AFE_ADDR_SHORT_POWER_CONTROL = 4'h8;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned AFE_STATE_LSB = 0;
  localparam int unsigned AFE_STATE_W = 4;
  localparam int unsigned AFE_SWITCH_SOURCE_BIT = 3;
  localparam int unsigned AFE_ANCILLARY_POWER_LSB = 4;
  localparam int unsigned AFE_HOUSEKEEPING_ADC_POWER_BIT = 9;
  localparam int unsigned AFE_TRIM_W = 6;
  localparam int unsigned AFE_TRIM_SIGN_BIT = 5;
  localparam int unsigned AFE_BIAS_W = 2;
  localparam int unsigned AFE_HK_CONFIG_W = 11;

  // ==========================================================================
  // State and switching codes
  // ==========================================================================
  localparam logic [2:0] AFE_LOW_FULL_POWERDOWN = 3'h0;
  localparam logic [2:0] AFE_LOW_IDLE = 3'h1;
  localparam logic [2:0] AFE_LOW_REFERENCE_ONLY = 3'h2;
  localparam logic [3:0] AFE_PIN_FAST_SLOW = 4'h3;
  localparam logic [3:0] AFE_PIN_SWITCHED_SCHEME_TWO = 4'h4;
  localparam logic [3:0] AFE_PIN_SLOW_SLOW = 4'h5;
  localparam logic [3:0] AFE_PIN_FAST_FAST = 4'h6;
  localparam logic [3:0] AFE_COMMAND_SWITCHED_SLOW_RECEIVE = 4'hb;
  localparam logic [3:0] AFE_COMMAND_SLOW_TRANSMIT = 4'hc;
  localparam logic [3:0] AFE_COMMAND_FAST_RECEIVE = 4'hd;
  localparam logic [3:0] AFE_COMMAND_FAST_TRANSMIT = 4'he;

  typedef enum logic [2:0] {
    AFE_FULL_POWERDOWN_STATE,
    AFE_IDLE_STATE,
    AFE_REFERENCE_ONLY_STATE,
    AFE_PIN_SWITCHED,
    AFE_COMMAND_SWITCHED
  } afe_mode_t;

  // Power and bus controls handed to the analog sections.
  typedef struct packed {
    logic rxAdcOn;
    logic txDacOn;
    logic [2:0] auxDacOn;
    logic auxAdcOn;
    logic clockOn;
    logic referenceOn;
    logic transmitSel;
    logic rxBusEn;
    logic txBusEn;
  } afe_power_t;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam afe_mode_t AFE_RST_MODE = AFE_PIN_SWITCHED;
  localparam logic [3:0] AFE_RST_CODE = AFE_PIN_SWITCHED_SCHEME_TWO;
  localparam logic [2:0] AFE_RST_ANCILLARY_OFF = 3'h0;
  localparam logic AFE_RST_HK_ADC_OFF = 1'b0;
  localparam logic [11:0] AFE_RST_LEVEL = 12'h000;
  localparam logic [5:0] AFE_RST_TRIM = 6'h00;
  localparam logic [1:0] AFE_RST_BIAS = 2'h0;
  localparam logic [10:0] AFE_RST_HK_CONFIG = 11'h000;
  localparam afe_power_t AFE_RST_POWER = '{rxAdcOn: 1'b1, txDacOn: 1'b0, auxDacOn: 3'h7,
    auxAdcOn: 1'b1, clockOn: 1'b1, referenceOn: 1'b1, transmitSel: 1'b0,
    rxBusEn: 1'b1, txBusEn: 1'b0};

endpackage
`default_nettype wire

// [afe_level_sync.sv]
// Three-stage synchroniser with agreement filter for one level.
// Assumes the input is asynchronous to sys_clk; output is on sys_clk.
`timescale 1ns/100ps
`default_nettype none

module afe_level_sync
  import afe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic asyncIn,
  output logic syncOut
);

  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic syncOut_r;
  logic syncOut_nxt;

  // ==========================================================================
  // Shift chain and filter
  // ==========================================================================
  // The output moves only when the second and third stages agree.
  always_comb begin
    stage_nxt = {stage_r[1:0], asyncIn};
    syncOut_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : syncOut_r;
  end

  // Registers the chain; the first stage feeds only the second.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stage_r <= 3'h0;
      syncOut_r <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      syncOut_r <= syncOut_nxt;
    end
  end

  assign syncOut = syncOut_r;

endmodule
`default_nettype wire

// [afe_word_receiver.sv]
// Serial word receiver running on the link clock.
// Assumes the link clock may stop between frames; select low frames a word.
`timescale 1ns/100ps
`default_nettype none

module afe_word_receiver
  import afe_pkg::*;
(
  input wire logic linkClk,
  input wire logic rstn,
  input wire logic linkSelN,
  input wire logic linkData,
  output afe_word_t wordOut,
  output logic wordToggle
);

  logic [4:0] bitCount_r;
  logic [4:0] bitCount_nxt;
  logic [14:0] shift_r;
  logic [14:0] shift_nxt;
  afe_word_t hold_r;
  afe_word_t hold_nxt;
  logic toggle_r;
  logic toggle_nxt;
  logic frameClr;
  logic linkRst;

  // Frame end or reset clears the bit count without needing a clock edge.
  assign frameClr = linkSelN | ~rstn;
  assign linkRst = ~rstn;

  // ==========================================================================
  // Shift and capture
  // ==========================================================================
  // Counts to sixteen and then stops, so extra bits in a frame are dropped.
  always_comb begin
    bitCount_nxt = bitCount_r;
    shift_nxt = {shift_r[13:0], linkData};
    hold_nxt = hold_r;
    toggle_nxt = toggle_r;
    if (bitCount_r != AFE_BITS_PER_WORD) begin
      bitCount_nxt = bitCount_r + 5'h01;
    end
    if (bitCount_r == AFE_BITS_PER_WORD - 5'h01) begin
      hold_nxt = {shift_r, linkData};
      toggle_nxt = ~toggle_r;
    end
  end

  // Bit counter, cleared by the frame's own select.
  always_ff @(posedge linkClk or posedge frameClr) begin
    if (frameClr) begin
      bitCount_r <= 5'h00;
    end else begin
      bitCount_r <= bitCount_nxt;
    end
  end

  // Word holder and toggle; held steady until the sixteenth link edge of the next frame.
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      shift_r <= 15'h0000;
      hold_r <= '0;
      toggle_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      hold_r <= hold_nxt;
      toggle_r <= toggle_nxt;
    end
  end

  assign wordOut = hold_r;
  assign wordToggle = toggle_r;

endmodule
`default_nettype wire

// [afe_serial_mode_control.sv]
// Control-word decoder and register bank for a dual converter front end.
// Assumes a three-wire serial host on the link clock and analog sections
// that take the registered power, level, trim and bias outputs.
`timescale 1ns/100ps
`default_nettype none

module afe_serial_mode_control
  import afe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic linkSelN,
  input wire logic linkData,
  input wire logic trPin,
  output afe_power_t powerCtl,
  output afe_mode_t modeState,
  output logic [11:0] ancillaryLevelOne,
  output logic [11:0] ancillaryLevelTwo,
  output logic [11:0] ancillaryLevelThree,
  output logic [5:0] inphaseTrim,
  output logic [5:0] quadratureTrim,
  output logic signed [5:0] inphaseOffset,
  output logic signed [5:0] quadratureOffset,
  output logic [1:0] outputBiasSelect,
  output logic [10:0] hkConfig,
  output logic hkStart
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  afe_word_t rxWord;
  logic rxToggle;
  logic toggleSync;
  logic trLevel;
  logic wordSeen_r;
  logic wordSeen_nxt;
  logic wordStrobe;

  afe_mode_t mode_r;
  afe_mode_t mode_nxt;
  logic [3:0] code_r;
  logic [3:0] code_nxt;
  logic hkAdcOff_r;
  logic hkAdcOff_nxt;
  logic [2:0] ancillaryOff_r;
  logic [2:0] ancillaryOff_nxt;
  afe_power_t power_r;
  afe_power_t power_nxt;

  logic [11:0] levelOne_r;
  logic [11:0] levelOne_nxt;
  logic [11:0] levelTwo_r;
  logic [11:0] levelTwo_nxt;
  logic [11:0] levelThree_r;
  logic [11:0] levelThree_nxt;
  logic [5:0] iTrim_r;
  logic [5:0] iTrim_nxt;
  logic [5:0] qTrim_r;
  logic [5:0] qTrim_nxt;
  logic signed [5:0] inphase_trim_r;
  logic signed [5:0] inphase_trim_nxt;
  logic signed [5:0] quadrature_trim_r;
  logic signed [5:0] quadrature_trim_nxt;
  logic [1:0] bias_r;
  logic [1:0] bias_nxt;
  logic [10:0] hkConfig_r;
  logic [10:0] hkConfig_nxt;
  logic hkStart_r;
  logic hkStart_nxt;

  logic powerWrite;
  logic [3:0] stateCode;
  logic hkOffEff;
  logic txNow;
  logic adcOffInTx;
  logic dacOffInRx;

  // Converts a sign-magnitude trim to two's complement.
  function automatic logic signed [5:0] trimToOffset(input logic [5:0] code);
    logic [5:0] mag;
    mag = {1'b0, code[AFE_TRIM_SIGN_BIT-1:0]};
    trimToOffset = code[AFE_TRIM_SIGN_BIT] ? -mag : mag;
  endfunction

  // ==========================================================================
  // Link side and crossings
  // ==========================================================================
  // Shift register on the link clock; publishes each whole word with a toggle.
  afe_word_receiver uReceiver (
    .linkClk(linkClk),
    .rstn(rstn),
    .linkSelN(linkSelN),
    .linkData(linkData),
    .wordOut(rxWord),
    .wordToggle(rxToggle)
  );

  // The word toggle crosses as a level; the held word is then stable.
  afe_level_sync uToggleSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .asyncIn(rxToggle),
    .syncOut(toggleSync)
  );

  // The transmit/receive pin is an outside level.
  afe_level_sync uPinSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .asyncIn(trPin),
    .syncOut(trLevel)
  );

  // A change of the synchronised toggle marks one complete word.
  assign wordStrobe = toggleSync ^ wordSeen_r;
  assign wordSeen_nxt = toggleSync;

  // ==========================================================================
  // Data registers
  // ==========================================================================
  // Only the addressed register takes the word; the rest hold.
  always_comb begin
    levelOne_nxt = levelOne_r;
    levelTwo_nxt = levelTwo_r;
    levelThree_nxt = levelThree_r;
    iTrim_nxt = iTrim_r;
    qTrim_nxt = qTrim_r;
    bias_nxt = bias_r;
    hkConfig_nxt = hkConfig_r;
    hkStart_nxt = 1'b0;
    if (wordStrobe) begin
      unique case (rxWord.addr)
        AFE_ADDR_ANCILLARY_LEVEL_ONE: begin
          levelOne_nxt = rxWord.data;
        end
        AFE_ADDR_ANCILLARY_LEVEL_TWO: begin
          levelTwo_nxt = rxWord.data;
        end
        AFE_ADDR_ANCILLARY_LEVEL_THREE: begin
          levelThree_nxt = rxWord.data;
        end
        AFE_ADDR_INPHASE_TRIM: begin
          iTrim_nxt = rxWord.data[AFE_TRIM_W-1:0];
        end
        AFE_ADDR_QUADRATURE_TRIM: begin
          qTrim_nxt = rxWord.data[AFE_TRIM_W-1:0];
        end
        AFE_ADDR_OUTPUT_BIAS_SELECT: begin
          bias_nxt = rxWord.data[AFE_BIAS_W-1:0];
        end
        AFE_ADDR_HOUSEKEEPING_CONVERSION: begin
          hkConfig_nxt = rxWord.data[AFE_HK_CONFIG_W-1:0];
          hkStart_nxt = 1'b1;
        end
        default: begin
          hkStart_nxt = 1'b0;
        end
      endcase
    end
    inphase_trim_nxt = trimToOffset(iTrim_r);
    quadrature_trim_nxt = trimToOffset(qTrim_r);
  end

  // Registers the data bank.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wordSeen_r <= 1'b0;
      levelOne_r <= AFE_RST_LEVEL;
      levelTwo_r <= AFE_RST_LEVEL;
      levelThree_r <= AFE_RST_LEVEL;
      iTrim_r <= AFE_RST_TRIM;
      qTrim_r <= AFE_RST_TRIM;
      inphase_trim_r <= AFE_RST_TRIM;
      quadrature_trim_r <= AFE_RST_TRIM;
      bias_r <= AFE_RST_BIAS;
      hkConfig_r <= AFE_RST_HK_CONFIG;
      hkStart_r <= 1'b0;
    end else begin
      wordSeen_r <= wordSeen_nxt;
      levelOne_r <= levelOne_nxt;
      levelTwo_r <= levelTwo_nxt;
      levelThree_r <= levelThree_nxt;
      iTrim_r <= iTrim_nxt;
      qTrim_r <= qTrim_nxt;
      inphase_trim_r <= inphase_trim_nxt;
      quadrature_trim_r <= quadrature_trim_nxt;
      bias_r <= bias_nxt;
      hkConfig_r <= hkConfig_nxt;
      hkStart_r <= hkStart_nxt;
    end
  end

  // ==========================================================================
  // Power-control registers
  // ==========================================================================
  // Both power registers share one decoder; only the wide one moves the aux bits.
  assign powerWrite = wordStrobe && ((rxWord.addr == AFE_ADDR_WIDE_POWER_CONTROL) ||
                                     (rxWord.addr == AFE_ADDR_SHORT_POWER_CONTROL));
  assign stateCode = rxWord.data[AFE_STATE_LSB +: AFE_STATE_W];

  // The aux-ADC bit in force for this write: new for wide, stored for short.
  assign hkOffEff = (rxWord.addr == AFE_ADDR_WIDE_POWER_CONTROL) ?
                    rxWord.data[AFE_HOUSEKEEPING_ADC_POWER_BIT] : hkAdcOff_r;

  // Decodes the state code; codes without a defined meaning leave the mode.
  always_comb begin
    mode_nxt = mode_r;
    code_nxt = code_r;
    hkAdcOff_nxt = hkAdcOff_r;
    ancillaryOff_nxt = ancillaryOff_r;
    if (wordStrobe && (rxWord.addr == AFE_ADDR_WIDE_POWER_CONTROL)) begin
      hkAdcOff_nxt = rxWord.data[AFE_HOUSEKEEPING_ADC_POWER_BIT];
      ancillaryOff_nxt = rxWord.data[AFE_ANCILLARY_POWER_LSB +: 3];
    end
    if (powerWrite) begin
      if (stateCode[2:0] == AFE_LOW_FULL_POWERDOWN) begin
        if (hkOffEff) begin
          mode_nxt = AFE_FULL_POWERDOWN_STATE;
        end
      end else if (stateCode[2:0] == AFE_LOW_IDLE) begin
        mode_nxt = AFE_IDLE_STATE;
      end else if (stateCode[2:0] == AFE_LOW_REFERENCE_ONLY) begin
        if (hkOffEff) begin
          mode_nxt = AFE_REFERENCE_ONLY_STATE;
        end
      end else if (!stateCode[AFE_SWITCH_SOURCE_BIT] &&
                   (stateCode <= AFE_PIN_FAST_FAST)) begin
        mode_nxt = AFE_PIN_SWITCHED;
        code_nxt = stateCode;
      end else if (stateCode[AFE_SWITCH_SOURCE_BIT] &&
                   (stateCode >= AFE_COMMAND_SWITCHED_SLOW_RECEIVE) &&
                   (stateCode <= AFE_COMMAND_FAST_TRANSMIT)) begin
        mode_nxt = AFE_COMMAND_SWITCHED;
        code_nxt = stateCode;
      end
    end
  end

  // Direction and per-direction converter shutdown for the active scheme.
  assign txNow = (mode_r == AFE_PIN_SWITCHED) ? trLevel :
                 ((code_r == AFE_COMMAND_SLOW_TRANSMIT) ||
                  (code_r == AFE_COMMAND_FAST_TRANSMIT));
  assign adcOffInTx = (code_r == AFE_PIN_FAST_SLOW) || (code_r == AFE_PIN_SLOW_SLOW) ||
                      (code_r == AFE_COMMAND_SLOW_TRANSMIT);
  assign dacOffInRx = (code_r == AFE_PIN_SWITCHED_SCHEME_TWO) || (code_r == AFE_PIN_SLOW_SLOW) ||
                      (code_r == AFE_COMMAND_SWITCHED_SLOW_RECEIVE);

  // Builds the section controls from the mode; idle and standby hold aux DACs.
  always_comb begin
    power_nxt = '0;
    unique case (mode_r)
      AFE_FULL_POWERDOWN_STATE: begin
        power_nxt = '0;
      end
      AFE_IDLE_STATE: begin
        power_nxt.auxDacOn = power_r.auxDacOn;
        power_nxt.auxAdcOn = ~hkAdcOff_r;
        power_nxt.clockOn = 1'b1;
        power_nxt.referenceOn = 1'b1;
      end
      AFE_REFERENCE_ONLY_STATE: begin
        power_nxt.auxDacOn = power_r.auxDacOn;
        power_nxt.referenceOn = 1'b1;
      end
      AFE_PIN_SWITCHED, AFE_COMMAND_SWITCHED: begin
        power_nxt.rxAdcOn = !(txNow && adcOffInTx);
        power_nxt.txDacOn = !(!txNow && dacOffInRx);
        power_nxt.auxDacOn = ~ancillaryOff_r;
        power_nxt.auxAdcOn = ~hkAdcOff_r;
        power_nxt.clockOn = 1'b1;
        power_nxt.referenceOn = 1'b1;
        power_nxt.transmitSel = txNow;
        power_nxt.rxBusEn = ~txNow;
        power_nxt.txBusEn = txNow;
      end
    endcase
  end

  // Registers the mode and section controls.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_r <= AFE_RST_MODE;
      code_r <= AFE_RST_CODE;
      hkAdcOff_r <= AFE_RST_HK_ADC_OFF;
      ancillaryOff_r <= AFE_RST_ANCILLARY_OFF;
      power_r <= AFE_RST_POWER;
    end else begin
      mode_r <= mode_nxt;
      code_r <= code_nxt;
      hkAdcOff_r <= hkAdcOff_nxt;
      ancillaryOff_r <= ancillaryOff_nxt;
      power_r <= power_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign powerCtl = power_r;
  assign modeState = mode_r;
  assign ancillaryLevelOne = levelOne_r;
  assign ancillaryLevelTwo = levelTwo_r;
  assign ancillaryLevelThree = levelThree_r;
  assign inphaseTrim = iTrim_r;
  assign quadratureTrim = qTrim_r;
  assign inphaseOffset = inphase_trim_r;
  assign quadratureOffset = quadrature_trim_r;
  assign outputBiasSelect = bias_r;
  assign hkConfig = hkConfig_r;
  assign hkStart = hkStart_r;

endmodule
`default_nettype wire

// [afe_serial_mode_control_monitor.sv]
// Assertion checker for the control-word decoder.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module afe_serial_mode_control_monitor
  import afe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic linkSelN,
  input wire afe_power_t powerCtl,
  input wire afe_mode_t modeState,
  input wire logic [11:0] ancillaryLevelOne,
  input wire logic [5:0] inphaseTrim,
  input wire logic signed [5:0] inphaseOffset,
  input wire logic [1:0] outputBiasSelect,
  input wire logic [10:0] hkConfig,
  input wire logic hkStart
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  // All checks use the system clock and rest while reset is low.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_reset_defaults:
    assert property ($rose(rstn) |-> powerCtl == AFE_RST_POWER && modeState == AFE_RST_MODE) else $error("Bad reset.");
  a_inphase_offset:
    assert property (1'b1 |=> $unsigned(inphaseOffset) == ($past(inphaseTrim[5]) ? 6'h00 - $past(inphaseTrim[4:0])
      : {1'b0, $past(inphaseTrim[4:0])})) else $error("Bad offset.");
  a_idle_outputs:
    assert property (modeState == AFE_IDLE_STATE |=> powerCtl[10:9] == 2'h0 && powerCtl[4:3] == 2'h3)
      else $error("Bad idle.");
  a_standby_outputs:
    assert property (modeState == AFE_REFERENCE_ONLY_STATE |=> powerCtl[10:9] == 2'h0 && powerCtl[5:3] == 3'h1)
      else $error("Bad standby.");
  a_shutdown_off:
    assert property (modeState == AFE_FULL_POWERDOWN_STATE |=> powerCtl[10:3] == 8'h00) else $error("Bad shutdown.");
  a_aux_held:
    assert property (modeState inside {AFE_IDLE_STATE, AFE_REFERENCE_ONLY_STATE} && $stable(modeState)
      |=> $stable(powerCtl.auxDacOn)) else $error("Aux enables moved.");
  a_quiet_link:
    assert property (linkSelN [*8] |-> $stable(ancillaryLevelOne) && $stable(outputBiasSelect) && $stable(hkConfig))
      else $error("Register moved without a word.");
  a_hk_single:
    assert property (hkStart |=> !hkStart) else $error("Start held too long.");
  a_hk_cause:
    assert property ($changed(hkConfig) |-> hkStart) else $error("Config without start.");
endmodule
bind afe_serial_mode_control afe_serial_mode_control_monitor u_monitor (.sys_clk, .rstn, .linkSelN, .powerCtl,
  .modeState, .ancillaryLevelOne, .inphaseTrim, .inphaseOffset, .outputBiasSelect, .hkConfig, .hkStart);
`default_nettype wire

// [afe_host_model.sv]
// Host model that shifts control words into the decoder.
// Assumes the caller spaces words by at least eight system clocks.
`timescale 1ns/100ps
`default_nettype none
module afe_host_model
  import afe_pkg::*;
(
  output logic linkClk,
  output logic linkSelN,
  output logic linkData
);
  // ==========================================================================
  // Frame driver
  // ==========================================================================
  // The link clock is parked low and the frame deselected between words.
  initial begin
    linkClk = 1'b0;
    linkSelN = 1'b1;
    linkData = 1'b1;
  end
  // Sends the first count bits of a word at a 12 ns link period; a wide power word goes with data bits 11:10 at zero.
  task automatic send(input afe_word_t w, input int count);
    logic [15:0] bits;
    bits = w;
    if (w.addr == AFE_ADDR_WIDE_POWER_CONTROL) begin
      bits[15:14] = 2'h0;
    end
    #3.3 linkSelN = 1'b0;
    for (int i = 15; i > 15 - count; i--) begin
      linkData = bits[i];
      #6 linkClk = 1'b1;
      #6 linkClk = 1'b0;
    end
    linkSelN = 1'b1;
    linkData = ~linkData;
  endtask
endmodule
`default_nettype wire

// [afe_serial_mode_control_tb_top.sv]
// Self-checking bench for the control-word decoder.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module afe_serial_mode_control_tb_top
  import afe_pkg::*;
;
  logic sys_clk, rstn, trPin, linkClk, linkSelN, linkData, hkStart;
  afe_power_t powerCtl;
  afe_mode_t modeState;
  logic [11:0] ancillaryLevelOne, ancillaryLevelTwo, ancillaryLevelThree;
  logic [5:0] inphaseTrim, quadratureTrim;
  logic signed [5:0] inphaseOffset, quadratureOffset;
  logic [1:0] outputBiasSelect;
  logic [10:0] hkConfig;
  int errCount = 0;
  int checks = 0;
  int hkStarts = 0;
  logic [3:0] codes [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'hb, 4'hc, 4'hd, 4'he};
  // ==========================================================================
  // Harness
  // ==========================================================================
  afe_serial_mode_control DUT (.sys_clk, .rstn, .linkClk, .linkSelN, .linkData, .trPin, .powerCtl, .modeState,
    .ancillaryLevelOne, .ancillaryLevelTwo, .ancillaryLevelThree, .inphaseTrim, .quadratureTrim, .inphaseOffset,
    .quadratureOffset, .outputBiasSelect, .hkConfig, .hkStart);
  afe_host_model host (.linkClk, .linkSelN, .linkData);
  // The system clock runs at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Counts cycles in which a conversion start is signalled.
  always @(posedge sys_clk) begin
    if (hkStart === 1'b1) begin
      hkStarts++;
    end
  end
  // Compares one value and reports a mismatch.
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      errCount++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Sends count bits of a word, then waits for it to take effect.
  task automatic wr(input logic [3:0] a, input logic [11:0] d, input int count = 16);
    @(posedge sys_clk);
    #1;
    host.send({d, a}, count);
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  // Expected receive-converter, transmit-converter, direction and bus-enable levels.
  function automatic logic [4:0] expSwitch(input logic [3:0] c, input logic p);
    logic s;
    s = c[3] ? ~c[0] : p;
    return {~(s & (c == 4'h3 | c == 4'h5 | c == 4'hc)), ~(~s & (c == 4'h4 | c == 4'h5 | c == 4'hb)), s, ~s, s};
  endfunction
  // Prints the totals and the verdict, then stops.
  task automatic endOfTest;
    $display("Checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Stops a hung run.
  initial begin
    #200000;
    errCount++;
    endOfTest;
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  // Reset, register traffic, then every switching and power state.
  initial begin
    rstn = 1'b0;
    trPin = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 rstn = 1'b1;
    chk("power", AFE_RST_POWER, powerCtl);
    chk("mode", AFE_RST_MODE, modeState);
    wr(4'h1, 12'ha5c);
    wr(4'h2, 12'h3c1);
    wr(4'h3, 12'hfff);
    chk("levelOne", 12'ha5c, ancillaryLevelOne);
    chk("levelTwo", 12'h3c1, ancillaryLevelTwo);
    chk("levelThree", 12'hfff, ancillaryLevelThree);
    wr(4'h4, 12'hfe1);
    wr(4'h5, 12'h01f);
    chk("iTrim", 12'h021, inphaseTrim);
    chk("iOff", 12'h03f, $unsigned(inphaseOffset));
    chk("qOff", 12'h01f, $unsigned(quadratureOffset));
    wr(4'h5, 12'hfa0);
    chk("qOff", 12'h000, $unsigned(quadratureOffset));
    chk("qTrim", 12'h020, quadratureTrim);
    wr(4'h6, 12'hffe);
    wr(4'h6, 12'h001, 10);
    wr(4'h9, 12'h001);
    chk("bias", 12'h002, outputBiasSelect);
    chk("levelOne", 12'ha5c, ancillaryLevelOne);
    hkStarts = 0;
    wr(4'h7, 12'h7a5);
    chk("hkConfig", 12'h7a5, hkConfig);
    chk("hkStarts", 12'h001, hkStarts[11:0]);
    for (int a = 0; a < 2; a++) begin
      for (int k = 0; k < 16; k++) begin
        trPin = k[0];
        wr(a[0] ? 4'h8 : 4'h0, {8'h00, codes[k / 2]});
        chk("switch", {7'h0, expSwitch(codes[k / 2], k[0])},
          {7'h0, powerCtl[10:9], powerCtl[2:0]});
        chk("aux", 12'h03f, {6'h0, powerCtl[8:3]});
      end
    end
    wr(4'h0, 12'h256);
    chk("aux", 12'h013, {6'h0, powerCtl[8:3]});
    wr(4'h0, 12'h201);
    chk("mode", AFE_IDLE_STATE, modeState);
    chk("aux", 12'h013, {6'h0, powerCtl[8:3]});
    wr(4'h8, 12'h002);
    chk("mode", AFE_REFERENCE_ONLY_STATE, modeState);
    wr(4'h8, 12'h000);
    chk("mode", AFE_FULL_POWERDOWN_STATE, modeState);
    trPin = ~trPin;
    repeat (8) @(posedge sys_clk);
    #1;
    chk("power", 12'h000, {4'h0, powerCtl[10:3]});
    endOfTest;
  end
endmodule
`default_nettype wire
